// ===== hw/iwtl_defs.svh
// Timing and layout constants of the isolated word transfer latch.
// Assumes the core clock runs at the rate given by IWTL_CLK_NS.
`ifndef IWTL_DEFS_SVH
`define IWTL_DEFS_SVH

// Core clock period in ns
`define IWTL_CLK_NS 100
// One barrier frame cycle of the internal sequencing clock, in ns
`define IWTL_BIT_NS 50
// Free-running word period in asynchronous mode, in ns
`define IWTL_WORD_NS 1000
// Clocks per frame cycle, rounded down, never below one
`define IWTL_BIT_CYC (((`IWTL_BIT_NS / `IWTL_CLK_NS) < 1) ? 1 : \
    (`IWTL_BIT_NS / `IWTL_CLK_NS))
// Clocks per asynchronous word, rounded down, never below one
`define IWTL_WORD_CYC (((`IWTL_WORD_NS / `IWTL_CLK_NS) < 1) ? 1 : \
    (`IWTL_WORD_NS / `IWTL_CLK_NS))
// Frame layout: sync cycles then data cycles
`define IWTL_SYNC_CYCLES 2
`define IWTL_DATA_BITS 8
// Output word after reset
`define IWTL_OUT_RESET 8'h00
// Divider and word counter widths
`define IWTL_CNT_W 8

`endif

// ===== hw/iwtl_pkg.sv
// Types shared by the word transfer latch modules.
// Assumes nothing of its surroundings.
package iwtl_pkg;

    // Barrier frame sequencer states
    typedef enum logic [1:0] {
        IWTL_IDLE = 2'b00,
        IWTL_FIRST_SYNC_CYCLE = 2'b01,
        IWTL_SECOND_SYNC_CYCLE = 2'b10,
        IWTL_DATA = 2'b11
    } iwtl_link_state_type;

endpackage : iwtl_pkg

// ===== hw/iwtl_link_if.sv
// Interface between latch control and the barrier frame sequencer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface iwtl_link_if;
    logic start;
    logic [7:0] tx_word;
    logic upset;
    logic busy;
    logic done;
    logic done_ok;
    logic [7:0] rx_word;

    // Control side
    modport ctrl (
        output start, tx_word, upset,
        input busy, done, done_ok, rx_word
    );

    // Sequencer side
    modport link (
        input start, tx_word, upset,
        output busy, done, done_ok, rx_word
    );
endinterface : iwtl_link_if

// ===== hw/iwtl_barrier_link.sv
// Barrier frame sequencer: two sync cycles, then eight data cycles.
// Assumes bit_tick_i is a one-cycle enable from the frame divider.
`timescale 1ns/1ps
`include "iwtl_defs.svh"
module iwtl_barrier_link #(
    parameter int DATA_BITS = `IWTL_DATA_BITS
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Frame cycle enable
    input wire logic bit_tick_i,
    // Control link
    iwtl_link_if.link lk
);
    iwtl_pkg::iwtl_link_state_type state_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_reg;
    logic [3:0] cnt_reg;
    logic corrupt_reg;
    logic done_reg;
    logic done_ok_reg;
    logic [7:0] word_reg;
    wire logic last_bit;
    wire logic [7:0] rx_shift;

    // Received bit enters at the top, low bit sent first
    assign rx_shift = {shift_reg[0], rx_reg[7:1]};
    assign last_bit = (cnt_reg == 4'(DATA_BITS - 1));
    assign lk.busy = (state_reg != iwtl_pkg::IWTL_IDLE);
    assign lk.done = done_reg;
    assign lk.done_ok = done_ok_reg;
    assign lk.rx_word = word_reg;

    // Frame sequencing; a new start overrides any running frame
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_reg <= iwtl_pkg::IWTL_IDLE;
            shift_reg <= 8'h00;
            rx_reg <= 8'h00;
            cnt_reg <= 4'h0;
            corrupt_reg <= 1'b0;
            done_reg <= 1'b0;
            done_ok_reg <= 1'b0;
            word_reg <= `IWTL_OUT_RESET;
        end else begin
            done_reg <= 1'b0;
            done_ok_reg <= 1'b0;
            if (lk.upset && lk.busy) begin
                corrupt_reg <= 1'b1;
            end
            if (bit_tick_i) begin
                case (state_reg)
                    iwtl_pkg::IWTL_FIRST_SYNC_CYCLE: begin
                        state_reg <= iwtl_pkg::IWTL_SECOND_SYNC_CYCLE;
                    end
                    iwtl_pkg::IWTL_SECOND_SYNC_CYCLE: begin
                        state_reg <= iwtl_pkg::IWTL_DATA;
                        cnt_reg <= 4'h0;
                    end
                    iwtl_pkg::IWTL_DATA: begin
                        rx_reg <= rx_shift;
                        shift_reg <= {1'b0, shift_reg[7:1]};
                        cnt_reg <= cnt_reg + 4'h1;
                        if (last_bit) begin
                            state_reg <= iwtl_pkg::IWTL_IDLE;
                            done_reg <= 1'b1;
                            done_ok_reg <= !corrupt_reg && !lk.upset;
                            word_reg <= rx_shift;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (lk.start) begin
                state_reg <= iwtl_pkg::IWTL_FIRST_SYNC_CYCLE;
                shift_reg <= lk.tx_word;
                corrupt_reg <= lk.upset;
            end
        end
    end
endmodule : iwtl_barrier_link

// ===== hw/iwtl_latch_top.sv
// Isolated word transfer latch: input latch, barrier frames, output latch.
// Assumes all pin inputs are asynchronous to core_clk_i.
// Assumes the host keeps synchronous falls within the rated rate.
// How it works
// - Mode pin low selects synchronous mode, high selects asynchronous mode.
// - Input buffer follows pins while input latch enable high, else holds.
// - Synchronous mode, enable low: no buffer load, no transmission starts.
// - Synchronous mode: each enable falling edge starts sending the buffer.
// - Enable rising during a frame reloads the buffer, frame unharmed.
// - Enable falling during a frame aborts it and restarts with new word.
// - Frame completing with output enable high updates output at once.
// - Output enable low at completion: keep old word until it rises.
// - All eight output bits change together in one cycle.
// - Asynchronous mode sends words continuously, one per microsecond.
// - Asynchronous mode: input enable only gates buffer loading.
// - Float control high releases all outputs, low drives latched word.
// - Upset frames are discarded; asynchronous resend restores output.
// - Free-running frame clock: two sync cycles then eight data cycles.
// - Synchronous start aligns to the next frame clock cycle.
// - Asynchronous new input waits for the next frame start.
`timescale 1ns/1ps
`include "iwtl_defs.svh"
module iwtl_latch_top #(
    parameter int DATA_BITS = `IWTL_DATA_BITS,
    parameter int BIT_CYC = `IWTL_BIT_CYC,
    parameter int WORD_CYC = `IWTL_WORD_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Input side pins
    input wire logic [7:0] data_in_i,
    input wire logic input_latch_enable_i,
    input wire logic async_mode_i,
    // Output side pins
    input wire logic output_latch_enable_i,
    input wire logic output_float_i,
    output logic [7:0] data_out_o,
    output logic [7:0] data_out_oe_o,
    // Barrier disturbance marker
    input wire logic barrier_upset_i,
    // Status
    output logic tx_busy_o,
    output logic word_pending_o,
    output logic frame_discard_o,
    output logic async_active_o
);
    // Pin synchronisers, first and second stage per pin
    logic [7:0] din_meta_reg;
    logic [7:0] din_sync_reg;
    logic ile_meta_reg;
    logic ile_sync_reg;
    logic async_meta_reg;
    logic async_sync_reg;
    logic ole_meta_reg;
    logic ole_sync_reg;
    logic float_meta_reg;
    logic float_sync_reg;
    logic upset_meta_reg;
    logic upset_sync_reg;
    wire logic [7:0] din_s;
    wire logic ile_s;
    wire logic async_s;
    wire logic ole_s;
    wire logic float_s;
    wire logic upset_s;

    // Frame clock divider and asynchronous word timer
    logic [`IWTL_CNT_W-1:0] div_cnt_reg;
    logic [`IWTL_CNT_W-1:0] word_cnt_reg;
    wire logic bit_tick;
    wire logic word_slot;
    wire logic div_wrap;
    wire logic word_wrap;

    // Input side state
    logic [7:0] in_buf_reg;
    logic ile_prev_reg;
    logic start_pend_reg;
    wire logic ile_fall;
    wire logic sync_start;
    wire logic async_start;

    // Output side state
    logic [7:0] rx_hold_reg;
    logic rx_pend_reg;
    logic [7:0] out_word_reg;
    logic [7:0] oe_reg;
    wire logic load_now;
    wire logic load_late;

    // Status registers
    logic busy_reg;
    logic discard_reg;
    logic async_reg;

    // Link to the frame sequencer
    iwtl_link_if lk ();

    // Input word pins, two stages before any logic reads them
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            din_meta_reg <= '0;
            din_sync_reg <= '0;
        end else begin
            din_meta_reg <= data_in_i;
            din_sync_reg <= din_meta_reg;
        end
    end

    // Input latch enable pin
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ile_meta_reg <= '0;
            ile_sync_reg <= '0;
        end else begin
            ile_meta_reg <= input_latch_enable_i;
            ile_sync_reg <= ile_meta_reg;
        end
    end

    // Mode select pin
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            async_meta_reg <= '0;
            async_sync_reg <= '0;
        end else begin
            async_meta_reg <= async_mode_i;
            async_sync_reg <= async_meta_reg;
        end
    end

    // Output latch enable pin
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ole_meta_reg <= '0;
            ole_sync_reg <= '0;
        end else begin
            ole_meta_reg <= output_latch_enable_i;
            ole_sync_reg <= ole_meta_reg;
        end
    end

    // Float control pin
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            float_meta_reg <= '0;
            float_sync_reg <= '0;
        end else begin
            float_meta_reg <= output_float_i;
            float_sync_reg <= float_meta_reg;
        end
    end

    // Barrier disturbance marker pin
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            upset_meta_reg <= '0;
            upset_sync_reg <= '0;
        end else begin
            upset_meta_reg <= barrier_upset_i;
            upset_sync_reg <= upset_meta_reg;
        end
    end

    // Second stages are the only readers of the first stages
    assign din_s = din_sync_reg;
    assign ile_s = ile_sync_reg;
    assign async_s = async_sync_reg;
    assign ole_s = ole_sync_reg;
    assign float_s = float_sync_reg;
    assign upset_s = upset_sync_reg;

    // Free-running frame clock enable, never stopped by mode
    // Sync starts stay aligned to it across mode changes
    assign bit_tick = (div_cnt_reg == '0);
    assign div_wrap = (div_cnt_reg == `IWTL_CNT_W'(BIT_CYC - 1));

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            div_cnt_reg <= '0;
        end else if (div_wrap) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + `IWTL_CNT_W'(1);
        end
    end

    // Word slot timer: one frame start per word period
    // Held at zero in sync mode, so the first async slot comes at once
    assign word_slot = (word_cnt_reg == '0);
    assign word_wrap = (word_cnt_reg == `IWTL_CNT_W'(WORD_CYC - 1));

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            word_cnt_reg <= '0;
        end else if (!async_s) begin
            word_cnt_reg <= '0;
        end else if (word_wrap) begin
            word_cnt_reg <= '0;
        end else begin
            word_cnt_reg <= word_cnt_reg + `IWTL_CNT_W'(1);
        end
    end

    // Transparent input buffer, frozen while the enable is low
    // Pins are synced bit by bit; hold the word steady around a fall
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            in_buf_reg <= 8'h00;
        end else if (ile_s) begin
            in_buf_reg <= din_s;
        end
    end

    // Falling edge of the input latch enable
    // Reset low can never form a fall, so no start follows reset
    assign ile_fall = ile_prev_reg && !ile_s;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ile_prev_reg <= 1'b0;
        end else begin
            ile_prev_reg <= ile_s;
        end
    end

    // A fall waits for the next frame clock cycle before it starts
    // Cleared in async mode so a stale fall never fires later
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            start_pend_reg <= 1'b0;
        end else if (async_s) begin
            start_pend_reg <= 1'b0;
        end else if (ile_fall) begin
            start_pend_reg <= 1'b1;
        end else if (bit_tick) begin
            start_pend_reg <= 1'b0;
        end
    end

    // Start decode per mode; no start without a fall in sync mode
    // An async start needs both a word slot and a frame tick
    assign sync_start = !async_s && start_pend_reg && bit_tick;
    assign async_start = async_s && word_slot && bit_tick;

    // Frame request towards the sequencer
    // The buffer is copied by the sequencer only on the start cycle
    assign lk.start = sync_start || async_start;
    assign lk.tx_word = in_buf_reg;
    assign lk.upset = upset_s;

    // Frame sequencer
    // It owns the frame states; this module owns the latches
    iwtl_barrier_link #(
        .DATA_BITS(DATA_BITS)
    ) u_link (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .bit_tick_i(bit_tick),
        .lk(lk.link)
    );

    // Output load: at completion if open, else when the enable opens
    // Level sensitive: a pending word loads while the enable is high
    assign load_now = lk.done_ok && ole_s;
    assign load_late = !lk.done_ok && rx_pend_reg && ole_s;

    // Received word held until the output latch opens
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rx_hold_reg <= `IWTL_OUT_RESET;
        end else if (lk.done_ok) begin
            rx_hold_reg <= lk.rx_word;
        end
    end

    // Pending flag; a new completion wins over a late load
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rx_pend_reg <= 1'b0;
        end else if (lk.done_ok) begin
            rx_pend_reg <= !ole_s;
        end else if (load_late) begin
            rx_pend_reg <= 1'b0;
        end
    end

    // Whole-word output register, all bits in one edge
    // One register for all bits keeps the output skew at zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            out_word_reg <= `IWTL_OUT_RESET;
        end else if (load_now) begin
            out_word_reg <= lk.rx_word;
        end else if (load_late) begin
            out_word_reg <= rx_hold_reg;
        end
    end

    // Output drive enable from the float control
    // Registered so the enables come straight from a flip-flop
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            oe_reg <= 8'h00;
        end else begin
            oe_reg <= {8{!float_s}};
        end
    end

    // Busy copy of the sequencer state
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= lk.busy;
        end
    end

    // Discard pulse for a disturbed frame, one cycle long
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            discard_reg <= 1'b0;
        end else begin
            discard_reg <= lk.done && !lk.done_ok;
        end
    end

    // Synchronised mode shown to the host
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            async_reg <= 1'b0;
        end else begin
            async_reg <= async_s;
        end
    end

    // Outputs straight from flip-flops
    assign data_out_o = out_word_reg;
    assign data_out_oe_o = oe_reg;
    assign tx_busy_o = busy_reg;
    assign word_pending_o = rx_pend_reg;
    assign frame_discard_o = discard_reg;
    assign async_active_o = async_reg;
endmodule : iwtl_latch_top

// ===== testbench/iwtl_latch_checker.sv
// Port-level assertions for the word transfer latch.
// Assumes a single core clock and the synchronous active-low reset.
`timescale 1ns/1ps
module iwtl_latch_checker (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Input side
    input wire logic [7:0] data_in_i,
    input wire logic input_latch_enable_i,
    input wire logic async_mode_i,
    // Output side
    input wire logic output_latch_enable_i,
    input wire logic output_float_i,
    input wire logic [7:0] data_out_o,
    input wire logic [7:0] data_out_oe_o,
    // Disturbance and status
    input wire logic barrier_upset_i,
    input wire logic tx_busy_o,
    input wire logic word_pending_o,
    input wire logic frame_discard_o,
    input wire logic async_active_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Properties on the output latch, frames and mode
    property p_rst_zero;
        $rose(rst_b_i) |-> data_out_o == 8'h00;
    endproperty
    property p_float_off;
        output_float_i[*4] |=> data_out_oe_o == 8'h00;
    endproperty
    property p_oe_whole;
        data_out_oe_o == 8'h00 || data_out_oe_o == 8'hff;
    endproperty
    property p_mode;
        $stable(async_mode_i)[*5] |-> async_active_o == async_mode_i;
    endproperty
    property p_frame_len;
        $rose(tx_busy_o) |-> tx_busy_o[*4];
    endproperty
    property p_async_run;
        async_active_o[*8] |-> ##[0:12] tx_busy_o;
    endproperty
    property p_discard;
        frame_discard_o && !word_pending_o |=> $stable(data_out_o);
    endproperty
    property p_hold_low;
        (!output_latch_enable_i)[*5] |-> $stable(data_out_o);
    endproperty
    property p_late_load;
        $rose(output_latch_enable_i) && word_pending_o
            |-> ##[1:5] !word_pending_o;
    endproperty

    a_rst_zero: assert property (p_rst_zero) else $error("out not zero");
    a_float_off: assert property (p_float_off) else $error("oe on");
    a_oe_whole: assert property (p_oe_whole) else $error("oe split");
    a_mode: assert property (p_mode) else $error("mode mismatch");
    a_frame_len: assert property (p_frame_len) else $error("short");
    a_async_run: assert property (p_async_run) else $error("idle");
    a_discard: assert property (p_discard) else $error("bad frame used");
    a_hold_low: assert property (p_hold_low) else $error("out moved");
    a_late_load: assert property (p_late_load) else $error("no load");

    // Main scenarios reached
    c_discard: cover property (frame_discard_o);
    c_pending: cover property ($rose(word_pending_o));
    c_async: cover property (async_active_o && tx_busy_o);
endmodule : iwtl_latch_checker

bind iwtl_latch_top iwtl_latch_checker chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .data_in_i(data_in_i),
    .input_latch_enable_i(input_latch_enable_i),
    .async_mode_i(async_mode_i),
    .output_latch_enable_i(output_latch_enable_i),
    .output_float_i(output_float_i), .data_out_o(data_out_o),
    .data_out_oe_o(data_out_oe_o), .barrier_upset_i(barrier_upset_i),
    .tx_busy_o(tx_busy_o), .word_pending_o(word_pending_o),
    .frame_discard_o(frame_discard_o), .async_active_o(async_active_o)
);

// ===== testbench/iwtl_bus_model.sv
// Output-side data bus seen by the host: resolves the tri-state pins.
// Assumes no pull resistor, so a released bus shows the inverted value.
`timescale 1ns/1ps
module iwtl_bus_model (
    // Clock
    input wire logic core_clk_i,
    // Pins from the latch
    input wire logic [7:0] data_out_o,
    input wire logic [7:0] data_out_oe_o,
    // Resolved bus
    output logic [7:0] bus_o
);
    logic [7:0] last_reg = 8'h00;

    // Track last driven value
    always @(posedge core_clk_i) begin
        if (data_out_oe_o === 8'hff) last_reg <= data_out_o;
    end

    // Released bus floats away from the last value
    assign bus_o = (data_out_oe_o === 8'hff) ? data_out_o : ~last_reg;
endmodule : iwtl_bus_model

// ===== testbench/iwtl_latch_bench.sv
// Self-checking bench for the word transfer latch.
// Assumes 10 MHz clock and about 15 clocks from pin fall to output.
`timescale 1ns/1ps
module iwtl_latch_bench;
    logic clk = 1'b0, rst_b = 1'b0, ile = 1'b1, mode = 1'b0;
    logic output_latch_enable = 1'b1, flt = 1'b1, upset = 1'b0;
    logic [7:0] din = 8'h00, w, a, model, dout, oe, bus;
    logic busy, pend, disc, act;
    int failures = 0, check_count = 0, ndisc = 0;
    logic [7:0] sent_q[$];

    iwtl_latch_top dut (
        .core_clk_i(clk), .rst_b_i(rst_b), .data_in_i(din),
        .input_latch_enable_i(ile), .async_mode_i(mode),
        .output_latch_enable_i(output_latch_enable), .output_float_i(flt),
        .data_out_o(dout), .data_out_oe_o(oe), .barrier_upset_i(upset),
        .tx_busy_o(busy), .word_pending_o(pend),
        .frame_discard_o(disc), .async_active_o(act)
    );
    iwtl_bus_model host (.core_clk_i(clk), .data_out_o(dout),
        .data_out_oe_o(oe), .bus_o(bus));

    // Clock and discard counter
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (disc === 1'b1) ndisc++;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Load word, then fall; falls stay at least five clocks apart
    task automatic send(input logic [7:0] v);
        din = v;
        ile = 1'b1;
        tick(2);
        ile = 1'b0;
        sent_q.push_back(v);
    endtask : send

    task automatic report_and_stop;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog
    initial begin
        #500000;
        failures++;
        report_and_stop;
    end

    // Main sequence
    initial begin
        void'($urandom(32'hd3a5a7a5));
        model = 8'h00;
        tick(2);
        rst_b = 1'b1;
        tick(3);
        check(dout, 8'h00);
        check(oe, 8'h00);
        flt = 1'b0;
        tick(4);
        check(oe, 8'hff);
        for (int i = 0; i < 4; i++) begin
            send(8'($urandom));
            tick(20);
            model = sent_q[$];
            check(bus, model);
        end
        din = ~model;
        tick(30);
        check(bus, model);
        output_latch_enable = 1'b0;
        send(8'($urandom));
        tick(20);
        check(bus, model);
        check({7'h00, pend}, 8'h01);
        output_latch_enable = 1'b1;
        tick(5);
        model = sent_q[$];
        check(bus, model);
        send($urandom);
        tick(3);
        send(~sent_q[$]);
        tick(20);
        model = sent_q[$];
        check(bus, model);
        a = 8'($urandom);
        send(a);
        tick(3);
        din = ~a;
        ile = 1'b1;
        tick(20);
        check(bus, a);
        ile = 1'b0;
        tick(20);
        model = ~a;
        check(bus, model);
        send(8'($urandom));
        tick(6);
        upset = 1'b1;
        tick(1);
        upset = 1'b0;
        tick(20);
        check(bus, model);
        check(ndisc[7:0], 8'h01);
        send(sent_q[$]);
        tick(20);
        model = sent_q[$];
        check(bus, model);
        mode = 1'b1;
        ile = 1'b1;
        for (int i = 0; i < 3; i++) begin
            w = 8'($urandom);
            din = w;
            tick(25);
            model = w;
            check(bus, model);
        end
        ile = 1'b0;
        din = ~w;
        tick(25);
        check(bus, model);
        upset = 1'b1;
        tick(1);
        upset = 1'b0;
        tick(25);
        check(bus, model);
        flt = 1'b1;
        tick(5);
        check(oe, 8'h00);
        report_and_stop;
    end
endmodule : iwtl_latch_bench
